// ### rtl/tx_arb_consts.vh
// register offsets, field positions and reset values of the transmit arbiter
`ifndef TX_ARB_CONSTS_VH
`define TX_ARB_CONSTS_VH
// ==========================================================================
// register byte offsets
`define TXA_OFS_IVL_RELOAD   5'h00
`define TXA_OFS_IVL_LIVE     5'h04
`define TXA_OFS_QUOTA_RELOAD 5'h08
`define TXA_OFS_QUOTA_LIVE   5'h0c
`define TXA_OFS_CTRL_STAT    5'h10
`define TXA_ADDR_W           3
`define TXA_IDX_IVL_RELOAD   3'h0
`define TXA_IDX_IVL_LIVE     3'h1
`define TXA_IDX_QUOTA_RELOAD 3'h2
`define TXA_IDX_QUOTA_LIVE   3'h3
`define TXA_IDX_CTRL_STAT    3'h4
// ==========================================================================
// control/status bit positions
`define TXA_BIT_PRIO_STAT    16
`define TXA_BIT_ITEST_ON     13
`define TXA_BIT_ITEST_OFF    12
`define TXA_BIT_ISTEP        11
`define TXA_BIT_QTEST_ON     10
`define TXA_BIT_QTEST_OFF    9
`define TXA_BIT_QSTEP        8
`define TXA_BIT_FSYNC_ON     7
`define TXA_BIT_FSYNC_OFF    6
`define TXA_BIT_ALLOC_ON     5
`define TXA_BIT_ALLOC_OFF    4
`define TXA_BIT_RATE_START   3
`define TXA_BIT_RATE_STOP    2
`define TXA_BIT_OPER_ON      1
`define TXA_BIT_OPER_OFF     0
// ==========================================================================
// reset values
`define TXA_CNT_W            24
`define TXA_RST_CNT          24'h000000
`define TXA_RST_RDATA        32'h00000000
`endif

// ### rtl/onoff_cmd.v
// one exclusive on/off command pair with two-bit readback
`timescale 1ns/1ps
module onoff_cmd (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       cmdOn,
  input  wire       cmdOff,
  output wire       state,
  output wire [1:0] readBack
);
  reg stateQ;
  reg stateD;

  // ==========================================================================
  // command decode: both bits at once, or neither, changes nothing
  always @* begin
    stateD = stateQ;
    if (cmdOn && !cmdOff) begin
      stateD = 1'b1;
    end else if (cmdOff && !cmdOn) begin
      stateD = 1'b0;
    end
  end

  // reset to off for every pair in this block
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= 1'b0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign state    = stateQ;
  assign readBack = stateQ ? 2'h2 : 2'h1;
endmodule // onoff_cmd

// ### rtl/down_counter.v
// loadable down counter with load and decrement inputs
`timescale 1ns/1ps
module down_counter #(
  parameter WIDTH = 24
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  input  wire             dec,
  output wire [WIDTH-1:0] count,
  output wire             isZero
);
  reg [WIDTH-1:0] countQ;

  // load wins over decrement; counter holds at zero rather than wrapping
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countQ <= {WIDTH{1'b0}};
    end else if (load) begin
      countQ <= loadValue;
    end else if (dec && (countQ != {WIDTH{1'b0}})) begin
      countQ <= countQ - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign count  = countQ;
  assign isZero = (countQ == {WIDTH{1'b0}});
endmodule // down_counter

// ### rtl/transmit_rate_arbiter.v
// transmit rate arbiter between synchronous and asynchronous queues
`timescale 1ns/1ps
`include "tx_arb_consts.vh"

// Functional notes
// - a 24-bit interval reload value sets interval length in clocks
// - a 24-bit quota reload sets synchronous transfer cycles per interval
// - status bit 16 high when quota nonzero or forced sync priority on
// - forced sync priority gives sync queue top priority regardless
// - bit 5 enables, bit 4 disables free bandwidth sharing; reset disabled
// - bit 3 starts, bit 2 stops rate control; reset stopped
// - bit 1 on, bit 0 off; while off nothing is granted; reset off
// - each on/off pair reads back 0b10 when on, 0b01 when off
// - bit 13/12 interval test mode on/off; bit 11 steps timer down
// - bit 10/9 quota test mode on/off; bit 8 steps quota down
module transmit_rate_arbiter (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [4:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output wire [31:0] avsReadData,
  output wire        avsWaitRequest,
  input  wire        syncReq,
  input  wire        asyncReq,
  input  wire        fifoReady,
  output wire        syncGrant,
  output wire        asyncGrant
);
  // ==========================================================================
  // registers and wires
  reg  [23:0] ivlReloadQ;
  reg  [23:0] quotaReloadQ;
  reg  [31:0] rdataQ;
  reg         ackQ;
  reg         syncGrantQ;
  reg         asyncGrantQ;
  reg         syncGrantD;
  reg         asyncGrantD;
  reg  [31:0] rdataD;
  wire [2:0]  regIdx;
  wire        wrAcc;
  wire        wrCtrl;
  wire        fullWord;
  wire [23:0] ivlCount;
  wire [23:0] quotaCount;
  wire        ivlZero;
  wire        quotaZero;
  wire        operOn;
  wire        rateOn;
  wire        allocOn;
  wire        fsyncOn;
  wire        itestOn;
  wire        qtestOn;
  wire [1:0]  operRb;
  wire [1:0]  rateRb;
  wire [1:0]  allocRb;
  wire [1:0]  fsyncRb;
  wire [1:0]  itestRb;
  wire [1:0]  qtestRb;
  wire        ivlExpire;
  wire        ivlLoad;
  wire        quotaLoad;
  wire        ivlDec;
  wire        quotaDec;
  wire        prioStat;

  // merge byte lanes of a write into the low 24 bits of an old value
  function [23:0] merge24;
    input [23:0] oldVal;
    input [31:0] newVal;
    input [3:0]  be;
    begin
      merge24 = oldVal;
      if (be[0]) merge24[7:0]   = newVal[7:0];
      if (be[1]) merge24[15:8]  = newVal[15:8];
      if (be[2]) merge24[23:16] = newVal[23:16];
    end
  endfunction

  // ==========================================================================
  // bus decode: one wait cycle, answer on the second cycle of a request
  assign regIdx         = avsAddress[4:2];
  assign wrAcc          = avsWrite && ackQ;
  assign avsWaitRequest = (avsRead || avsWrite) && !ackQ;
  assign avsReadData    = rdataQ;
  assign fullWord       = 1'b1;
  assign wrCtrl = wrAcc && (regIdx == `TXA_IDX_CTRL_STAT);

  // ack toggles high for one cycle after a request has waited once
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avsRead || avsWrite) && !ackQ;
    end
  end

  // ==========================================================================
  // reload value registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ivlReloadQ   <= `TXA_RST_CNT;
      quotaReloadQ <= `TXA_RST_CNT;
    end else if (wrAcc) begin
      if (regIdx == `TXA_IDX_IVL_RELOAD) begin
        ivlReloadQ <= merge24(ivlReloadQ, avsWriteData, avsByteEnable);
      end
      if (regIdx == `TXA_IDX_QUOTA_RELOAD) begin
        quotaReloadQ <= merge24(quotaReloadQ, avsWriteData,
                                avsByteEnable);
      end
    end
  end

  // ==========================================================================
  // command pairs; a command bit counts only when its byte lane is enabled
  onoff_cmd uOper (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_OPER_ON]),
    .cmdOff   (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_OPER_OFF]),
    .state    (operOn),
    .readBack (operRb)
  );
  onoff_cmd uRate (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_RATE_START]),
    .cmdOff   (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_RATE_STOP]),
    .state    (rateOn),
    .readBack (rateRb)
  );
  onoff_cmd uAlloc (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_ALLOC_ON]),
    .cmdOff   (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_ALLOC_OFF]),
    .state    (allocOn),
    .readBack (allocRb)
  );
  onoff_cmd uFsync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_FSYNC_ON]),
    .cmdOff   (wrCtrl && avsByteEnable[0] &&
               avsWriteData[`TXA_BIT_FSYNC_OFF]),
    .state    (fsyncOn),
    .readBack (fsyncRb)
  );
  onoff_cmd uItest (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[1] &&
               avsWriteData[`TXA_BIT_ITEST_ON]),
    .cmdOff   (wrCtrl && avsByteEnable[1] &&
               avsWriteData[`TXA_BIT_ITEST_OFF]),
    .state    (itestOn),
    .readBack (itestRb)
  );
  onoff_cmd uQtest (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cmdOn    (wrCtrl && avsByteEnable[1] &&
               avsWriteData[`TXA_BIT_QTEST_ON]),
    .cmdOff   (wrCtrl && avsByteEnable[1] &&
               avsWriteData[`TXA_BIT_QTEST_OFF]),
    .state    (qtestOn),
    .readBack (qtestRb)
  );

  // ==========================================================================
  // counter control; test mode freezes free running so steps are exact;
  // quota is charged on the grant decision, not the registered grant,
  // so a spent quota never lets one extra sync cycle through
  assign ivlExpire = rateOn && !itestOn && ivlZero;
  assign ivlLoad   = ivlExpire ||
                     (wrAcc && regIdx == `TXA_IDX_IVL_LIVE);
  assign quotaLoad = ivlExpire ||
                     (wrAcc && regIdx == `TXA_IDX_QUOTA_LIVE);
  assign ivlDec    = (rateOn && !itestOn) ||
                     (itestOn && wrCtrl && avsByteEnable[1] &&
                      avsWriteData[`TXA_BIT_ISTEP]);
  assign quotaDec  = (rateOn && !qtestOn && syncGrantD && !fsyncOn) ||
                     (qtestOn && wrCtrl && avsByteEnable[1] &&
                      avsWriteData[`TXA_BIT_QSTEP]);

  down_counter #(.WIDTH(`TXA_CNT_W)) uIvl (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (ivlLoad),
    .loadValue (ivlExpire ? ivlReloadQ : avsWriteData[23:0]),
    .dec       (ivlDec),
    .count     (ivlCount),
    .isZero    (ivlZero)
  );
  down_counter #(.WIDTH(`TXA_CNT_W)) uQuota (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (quotaLoad),
    .loadValue (ivlExpire ? quotaReloadQ : avsWriteData[23:0]),
    .dec       (quotaDec),
    .count     (quotaCount),
    .isZero    (quotaZero)
  );

  assign prioStat = !quotaZero || fsyncOn;

  // ==========================================================================
  // grant selection: sync first while it holds priority, else async;
  // with sharing enabled, idle bandwidth goes to whichever queue asks
  always @* begin
    syncGrantD  = 1'b0;
    asyncGrantD = 1'b0;
    if (operOn && fifoReady) begin
      if (fsyncOn) begin
        syncGrantD  = syncReq;
        asyncGrantD = !syncReq && asyncReq && allocOn;
      end else if (!rateOn) begin
        syncGrantD  = syncReq;
        asyncGrantD = !syncReq && asyncReq;
      end else if (!quotaZero && syncReq) begin
        syncGrantD  = 1'b1;
      end else if (asyncReq) begin
        asyncGrantD = 1'b1;
      end else if (allocOn) begin
        syncGrantD  = syncReq;
      end
    end
  end

  // grants are registered so they stand one clean cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncGrantQ  <= 1'b0;
      asyncGrantQ <= 1'b0;
    end else begin
      syncGrantQ  <= syncGrantD;
      asyncGrantQ <= asyncGrantD;
    end
  end

  assign syncGrant  = syncGrantQ;
  assign asyncGrant = asyncGrantQ;

  // ==========================================================================
  // read data mux; unmapped indices read zero
  always @* begin
    rdataD = `TXA_RST_RDATA;
    case (regIdx)
      `TXA_IDX_IVL_RELOAD:   rdataD[23:0] = ivlReloadQ;
      `TXA_IDX_IVL_LIVE:     rdataD[23:0] = ivlCount;
      `TXA_IDX_QUOTA_RELOAD: rdataD[23:0] = quotaReloadQ;
      `TXA_IDX_QUOTA_LIVE:   rdataD[23:0] = quotaCount;
      `TXA_IDX_CTRL_STAT: begin
        rdataD[`TXA_BIT_PRIO_STAT] = prioStat;
        rdataD[13:12] = itestRb;
        rdataD[10:9]  = qtestRb;
        rdataD[7:6]   = fsyncRb;
        rdataD[5:4]   = allocRb;
        rdataD[3:2]   = rateRb;
        rdataD[1:0]   = operRb;
      end
      default: rdataD = `TXA_RST_RDATA;
    endcase
  end

  // read data latched on the wait cycle, valid when waitrequest drops
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdataQ <= `TXA_RST_RDATA;
    end else if (avsRead && !ackQ && fullWord) begin
      rdataQ <= rdataD;
    end
  end
endmodule // transmit_rate_arbiter

// ### verif/tx_arb_sva.sv
// port-level assertions for the transmit rate arbiter
`timescale 1ns/1ps
module tx_arb_sva (
  input logic        clk,
  input logic        sys_rst,
  input logic [4:0]  avsAddress,
  input logic        avsRead,
  input logic        avsWrite,
  input logic [31:0] avsWriteData,
  input logic [3:0]  avsByteEnable,
  input logic [31:0] avsReadData,
  input logic        avsWaitRequest,
  input logic        syncReq,
  input logic        asyncReq,
  input logic        fifoReady,
  input logic        syncGrant,
  input logic        asyncGrant
);
  logic onQ, rateQ, syncQ;
  wire  [7:0] cmd = avsWriteData[7:0];
  wire  ctlWr = avsWrite && !avsWaitRequest && avsAddress[4:2] == 3'h4
                && avsByteEnable[0];
  wire  ctlRd = avsRead && !avsWaitRequest && avsAddress[4:2] == 3'h4;
  // shadow of three on/off pairs, as the state is not visible at the ports
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {onQ, rateQ, syncQ} <= 3'b000;
    end else if (ctlWr) begin
      if (cmd[1] ^ cmd[0]) onQ <= cmd[1];
      if (cmd[3] ^ cmd[2]) rateQ <= cmd[3];
      if (cmd[7] ^ cmd[6]) syncQ <= cmd[7];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence busAsk;
    (avsRead || avsWrite) && avsWaitRequest;
  endsequence
  sequence syncAsk;
    syncReq && fifoReady;
  endsequence
  // sync has the upper hand: forced, or rate control stopped
  sequence syncFirst;
    onQ && (syncQ || !rateQ);
  endsequence
  // ==========================================================
  // bus and grant relations; grants follow the state one cycle late
  a_wait_once: assert property (busAsk |=> !avsWaitRequest)
    else $error("waitrequest longer than one cycle");
  a_wait_first: assert property (
    $rose(avsRead || avsWrite) |-> avsWaitRequest)
    else $error("request answered without a wait");
  a_grant_excl: assert property (!(syncGrant && asyncGrant))
    else $error("both grants high");
  a_off_quiet: assert property (
    !onQ |=> !syncGrant && !asyncGrant)
    else $error("grant while arbiter off");
  a_sync_cause: assert property (
    syncGrant |-> $past(syncReq && fifoReady))
    else $error("sync grant without request");
  a_async_cause: assert property (
    asyncGrant |-> $past(asyncReq && fifoReady))
    else $error("async grant without request");
  a_sync_first: assert property (
    syncAsk ##0 syncFirst |=> syncGrant)
    else $error("sync request not served first");
  a_ctrl_readback: assert property (
    ctlRd |-> avsReadData[1:0] == {onQ, !onQ} &&
              (!syncQ || avsReadData[16]))
    else $error("control readback wrong");
  a_unmapped_zero: assert property (
    avsRead && !avsWaitRequest && avsAddress[4:2] > 3'h4 |->
    avsReadData == 32'h0)
    else $error("unmapped read not zero");
endmodule // tx_arb_sva

bind transmit_rate_arbiter tx_arb_sva tx_arb_sva_i (.clk, .sys_rst,
  .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
  .avsReadData, .avsWaitRequest, .syncReq, .asyncReq, .fifoReady,
  .syncGrant, .asyncGrant);

// ### verif/tx_queue_model.sv
// queue pair and transmit fifo stand-in that counts grants received
`timescale 1ns/1ps
module tx_queue_model (
  input  logic        clk,
  input  logic        sys_rst,
  input  logic        syncWant,
  input  logic        asyncWant,
  input  logic        stall,
  input  logic        clear,
  input  logic        syncGrant,
  input  logic        asyncGrant,
  output logic        syncReq,
  output logic        asyncReq,
  output logic        fifoReady,
  output logic [15:0] syncCount,
  output logic [15:0] asyncCount
);
  // requests are levels held while data waits; stall models a full fifo
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst || clear) begin
      syncCount  <= 16'h0000;
      asyncCount <= 16'h0000;
    end else begin
      syncCount  <= syncCount + 16'(syncGrant);
      asyncCount <= asyncCount + 16'(asyncGrant);
    end
  end
  assign syncReq   = syncWant;
  assign asyncReq  = asyncWant;
  assign fifoReady = !stall;
endmodule // tx_queue_model

// ### verif/testbench.sv
// self-checking bench for the transmit rate arbiter
`timescale 1ns/1ps
module testbench;
  logic clk = 0, sys_rst = 1, avsRead = 0, avsWrite = 0;
  logic syncWant = 0, asyncWant = 0, stall = 0, clear = 0;
  logic [4:0]  avsAddress = 5'h00;
  logic [31:0] avsWriteData = 32'h0, avsReadData;
  logic        avsWaitRequest, syncReq, asyncReq, fifoReady;
  logic        syncGrant, asyncGrant;
  logic [15:0] syncCount, asyncCount;
  int fails = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  transmit_rate_arbiter transmit_rate_arbiter_i (.clk, .sys_rst,
    .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable(4'hf), .avsReadData, .avsWaitRequest, .syncReq,
    .asyncReq, .fifoReady, .syncGrant, .asyncGrant);
  tx_queue_model tx_queue_model_i (.clk, .sys_rst, .syncWant, .asyncWant,
    .stall, .clear, .syncGrant, .asyncGrant, .syncReq, .asyncReq,
    .fifoReady, .syncCount, .asyncCount);
  // ==========================================================
  // verdict and watchdog; the run needs about two hundred cycles
  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  // ==========================================================
  // bus access: hold until waitrequest is seen low at a rising edge
  task automatic busOp(input bit wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= !wr;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    logic [31:0] x;
    busOp(1'b1, a, d, x);
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] e, string nm);
    logic [31:0] x;
    busOp(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask
  // count grants over n cycles from a clean start; counts are read at
  // the falling edge so the last counted grant has settled
  task automatic grants(int n, logic [15:0] es, logic [15:0] ea,
                        string nm);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk({nm, "Sync"}, {16'h0, es}, {16'h0, syncCount});
    chk({nm, "Async"}, {16'h0, ea}, {16'h0, asyncCount});
    @(posedge clk);
  endtask
  // expected control word from the pair states
  function automatic logic [31:0] ctl(bit p, it, qt, fs, al, rc, op);
    return {15'h0, p, 2'b00, it, !it, 1'b0, qt, !qt, 1'b0,
            fs, !fs, al, !al, rc, !rc, op, !op};
  endfunction
  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(5'h10, ctl(0, 0, 0, 0, 0, 0, 0), "ctrlReset");
    rd(5'h0c, 32'h0, "quotaLiveReset");
    rd(5'h14, 32'h0, "unmapped");
    wr(5'h08, 32'hffffffff);
    rd(5'h08, 32'h00ffffff, "quotaReload");
    wr(5'h00, 32'h12345678);
    rd(5'h00, 32'h00345678, "ivlReload");
    syncWant <= 1'b1;
    asyncWant <= 1'b1;
    grants(10, 16'd0, 16'd0, "offGrants");
    wr(5'h10, 32'h00000003);
    wr(5'h10, 32'h00000000);
    rd(5'h10, ctl(0, 0, 0, 0, 0, 0, 0), "ctrlBoth");
    wr(5'h10, 32'h00000002);
    rd(5'h10, ctl(0, 0, 0, 0, 0, 0, 1), "ctrlOn");
    grants(10, 16'd10, 16'd0, "stopped");
    wr(5'h10, 32'h00000080);
    rd(5'h10, ctl(1, 0, 0, 1, 0, 0, 1), "ctrlForced");
    wr(5'h10, 32'h00000040);
    wr(5'h0c, 32'h00000005);
    wr(5'h10, 32'h00000400);
    wr(5'h10, 32'h00000100);
    rd(5'h0c, 32'h00000004, "quotaStep");
    wr(5'h04, 32'h00000003);
    wr(5'h10, 32'h00002000);
    wr(5'h10, 32'h00000800);
    rd(5'h04, 32'h00000002, "ivlStep");
    rd(5'h10, ctl(1, 1, 1, 0, 0, 0, 1), "ctrlTest");
    wr(5'h10, 32'h00001200);
    syncWant <= 1'b0;
    wr(5'h04, 32'h000003e8);
    wr(5'h0c, 32'h00000003);
    wr(5'h10, 32'h00000008);
    syncWant <= 1'b1;
    grants(20, 16'd3, 16'd17, "quota");
    rd(5'h10, ctl(0, 0, 0, 0, 0, 1, 1), "ctrlSpent");
    asyncWant <= 1'b0;
    grants(10, 16'd0, 16'd0, "noAlloc");
    wr(5'h10, 32'h00000020);
    grants(10, 16'd10, 16'd0, "alloc");
    syncWant <= 1'b0;
    wr(5'h08, 32'h00000002);
    wr(5'h04, 32'h00000004);
    repeat (15) @(posedge clk);
    rd(5'h0c, 32'h00000002, "quotaReloaded");
    tally_and_finish;
  end
endmodule // testbench
